// ==== step_fault_output_regs.svh ====
// Register offsets, field positions, reset values and timing counts.
// Assumes inclusion by the step generator package user; definitions only.
`ifndef STEP_FAULT_OUTPUT_REGS_SVH
`define STEP_FAULT_OUTPUT_REGS_SVH

// ============================================================
// Register byte offsets
`define OFS_GLOBAL_CONFIG 8'h00
`define OFS_VELOCITY 8'h04
`define OFS_THERMAL_CFG 8'h08
`define OFS_DRIVER_CTRL 8'h0c
`define OFS_DRV_STATUS 8'h10
`define OFS_POSITION 8'h14
`define OFS_STEP_INTERVAL 8'h18
`define OFS_IRQ_STATUS 8'h1c
`define OFS_IRQ_MASK 8'h20

// ============================================================
// Field positions
`define CFG_INDEX_STEP 0
`define CFG_STALL_EN 1
`define DCTRL_ENABLE 0
`define ST_PREWARN 0
`define ST_SHUTDOWN 1
`define ST_SHORT_GND_A 2
`define ST_SHORT_GND_B 3
`define ST_SHORT_SUP_A 4
`define ST_SHORT_SUP_B 5
`define ST_OPEN_A 6
`define ST_OPEN_B 7
`define ST_STALL 8
`define ST_BRIDGE_A_ON 9
`define ST_BRIDGE_B_ON 10

// ============================================================
// Reset values and counts
`define RST_GLOBAL_CONFIG 2'h0
`define RST_THERMAL_CFG 2'h0
`define SHORT_RETRIES 2'h3
`define PHASE_BITS 24
`define IRQ_BITS 9

`endif

// ==== step_fault_output_pkg.sv ====
// Types shared by the step generator and diagnostics block.
// Assumes no surroundings beyond the register header.
`default_nettype none

package step_fault_output_pkg;
  typedef enum logic [1:0] {
    THERMAL_143_PW120,
    THERMAL_150_PW120,
    THERMAL_150_PW143,
    THERMAL_157_PW143
  } thermal_sel_t;
  typedef enum logic [1:0] {
    SHORT_IDLE,
    SHORT_RETRY,
    SHORT_LATCHED
  } short_state_t;
endpackage

`default_nettype wire

// ==== step_generator_diagnostics.sv ====
// Internal velocity step generator with driver diagnostics and protection.
// Assumes an AXI4-Lite master on aclk; analog comparators arrive as pins.
//
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/100ps
`include "step_fault_output_regs.svh"
`default_nettype none

module step_generator_diagnostics
  import step_fault_output_pkg::*;
#(
  parameter int VEL_BITS = 24,
  parameter int STEP_INTERVAL_BITS = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // AXI4-Lite slave
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Analog sensing, asynchronous
  input wire logic [3:0] temp_above,
  input wire logic otp_thermal_150,
  input wire logic short_gnd_a,
  input wire logic short_gnd_b,
  input wire logic short_sup_a,
  input wire logic short_sup_b,
  input wire logic open_load_a,
  input wire logic open_load_b,
  input wire logic stall_detect,
  // Outputs
  output logic bridge_a_enable,
  output logic bridge_b_enable,
  output logic microstep_pulse,
  output logic microstep_dir,
  output logic fault_output,
  output logic index_output,
  output logic irq
);

  // ============================================================
  // Pin synchronisers: three stages, change counts when 2 and 3 agree
  localparam int NPIN = 12;
  logic [NPIN-1:0] pin_raw, sync1, sync2, sync3, pin_s;
  assign pin_raw = {otp_thermal_150, stall_detect, open_load_b, open_load_a,
                    short_sup_b, short_sup_a, short_gnd_b, short_gnd_a, temp_above};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else if (clk_en) begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  generate
    for (genvar i = 0; i < NPIN; i++) begin : g_pin
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pin_s[i] <= 1'b0;
        end else if (clk_en && sync2[i] == sync3[i]) begin
          pin_s[i] <= sync3[i];
        end
      end
    end
  endgenerate
  logic [3:0] temp_lvl;
  logic sgnd_a, sgnd_b, ssup_a, ssup_b, ol_a, ol_b, stall_s, otp150;
  assign temp_lvl = pin_s[3:0];
  assign {otp150, stall_s, ol_b, ol_a, ssup_b, ssup_a, sgnd_b, sgnd_a} = pin_s[11:4];

  // ============================================================
  // Register storage
  logic [1:0] global_config;
  logic [VEL_BITS-1:0] internal_velocity_setting;
  logic [1:0] thermal_cfg;
  logic drv_enable;
  logic [`IRQ_BITS-1:0] irq_status, irq_mask, irq_event;
  logic [9:0] microstep_position_count;
  logic [STEP_INTERVAL_BITS-1:0] step_interval_measure;
  logic [10:0] drv_status;

  // ============================================================
  // AXI4-Lite write path: address and data taken in either order
  logic aw_held, w_held, wr_fire, rd_fire;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign wr_fire = aw_held && w_held && !bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
    end else if (clk_en) begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        case (aw_addr_q)
          `OFS_GLOBAL_CONFIG, `OFS_VELOCITY, `OFS_THERMAL_CFG, `OFS_DRIVER_CTRL,
          `OFS_IRQ_STATUS, `OFS_IRQ_MASK: bresp <= 2'h0;
          default: bresp <= 2'h2;
        endcase
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  logic [31:0] wr_val;
  assign wr_val = merge(32'h0000_0000, w_data_q, w_strb_q);
  logic wr_global_config, wr_vel, wr_therm, wr_dctrl, wr_istat, wr_imask;
  assign wr_global_config = wr_fire && aw_addr_q == `OFS_GLOBAL_CONFIG;
  assign wr_vel = wr_fire && aw_addr_q == `OFS_VELOCITY;
  assign wr_therm = wr_fire && aw_addr_q == `OFS_THERMAL_CFG;
  assign wr_dctrl = wr_fire && aw_addr_q == `OFS_DRIVER_CTRL;
  assign wr_istat = wr_fire && aw_addr_q == `OFS_IRQ_STATUS;
  assign wr_imask = wr_fire && aw_addr_q == `OFS_IRQ_MASK;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      global_config <= `RST_GLOBAL_CONFIG;
      internal_velocity_setting <= '0;
      drv_enable <= 1'b0;
      irq_mask <= '0;
    end else if (clk_en) begin
      if (wr_global_config) begin
        global_config <= 2'(merge({30'h0, global_config}, w_data_q, w_strb_q));
      end
      // Taken at once, no ramp between rates
      if (wr_vel) begin
        internal_velocity_setting <= VEL_BITS'(merge({{(32-VEL_BITS){1'b0}},
          internal_velocity_setting}, w_data_q, w_strb_q));
      end
      if (wr_dctrl) begin
        drv_enable <= w_data_q[`DCTRL_ENABLE];
      end
      if (wr_imask) begin
        irq_mask <= wr_val[`IRQ_BITS-1:0];
      end
    end
  end

  // ============================================================
  // Thermal selection: 157 option only by bus, 150 also by OTP strap
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thermal_cfg <= `RST_THERMAL_CFG;
    end else if (clk_en) begin
      if (wr_therm) begin
        thermal_cfg <= w_data_q[1:0];
      end else if (otp150 && thermal_cfg == THERMAL_143_PW120) begin
        thermal_cfg <= THERMAL_150_PW120;
      end
    end
  end

  // temp_above[0..3] = above 120, 143, 150, 157
  logic pw_hot, sd_hot, thermal_shutdown_flag;
  always_comb begin
    unique case (thermal_sel_t'(thermal_cfg))
      THERMAL_143_PW120: begin
        sd_hot = temp_lvl[1];
        pw_hot = temp_lvl[0];
      end
      THERMAL_150_PW120: begin
        sd_hot = temp_lvl[2];
        pw_hot = temp_lvl[0];
      end
      THERMAL_150_PW143: begin
        sd_hot = temp_lvl[2];
        pw_hot = temp_lvl[1];
      end
      THERMAL_157_PW143: begin
        sd_hot = temp_lvl[3];
        pw_hot = temp_lvl[1];
      end
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thermal_shutdown_flag <= 1'b0;
    end else if (clk_en) begin
      if (sd_hot) begin
        thermal_shutdown_flag <= 1'b1;
      end else if (!pw_hot) begin
        thermal_shutdown_flag <= 1'b0;
      end
    end
  end

  // ============================================================
  // Short protection per bridge: three retries then latch until re-enable
  short_state_t sst [2];
  logic [1:0] srt [2];
  logic [1:0] s_gnd, s_sup, s_flag_g, s_flag_s, s_raw;
  logic drv_enable_q;
  assign s_gnd = {sgnd_b, sgnd_a};
  assign s_sup = {ssup_b, ssup_a};
  assign s_raw = s_gnd | s_sup;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drv_enable_q <= 1'b0;
    end else if (clk_en) begin
      drv_enable_q <= drv_enable;
    end
  end
  generate
    for (genvar b = 0; b < 2; b++) begin : g_short
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          sst[b] <= SHORT_IDLE;
          srt[b] <= 2'h0;
          s_flag_g[b] <= 1'b0;
          s_flag_s[b] <= 1'b0;
        end else if (clk_en) begin
          unique case (sst[b])
            SHORT_IDLE: begin
              if (s_raw[b] && drv_enable) begin
                sst[b] <= SHORT_RETRY;
                srt[b] <= 2'h1;
              end
            end
            SHORT_RETRY: begin
              if (!s_raw[b]) begin
                sst[b] <= SHORT_IDLE;
              end else if (srt[b] == `SHORT_RETRIES) begin
                sst[b] <= SHORT_LATCHED;
                s_flag_g[b] <= s_gnd[b];
                s_flag_s[b] <= s_sup[b];
              end else begin
                srt[b] <= srt[b] + 2'h1;
              end
            end
            SHORT_LATCHED: begin
              // Released only by the enable rising again
              if (drv_enable && !drv_enable_q) begin
                sst[b] <= SHORT_IDLE;
                s_flag_g[b] <= 1'b0;
                s_flag_s[b] <= 1'b0;
              end
            end
            default: sst[b] <= SHORT_IDLE;
          endcase
        end
      end
    end
  endgenerate
  logic [1:0] bridge_off;
  assign bridge_off = {sst[1] == SHORT_LATCHED, sst[0] == SHORT_LATCHED};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bridge_a_enable <= 1'b0;
      bridge_b_enable <= 1'b0;
    end else if (clk_en) begin
      bridge_a_enable <= drv_enable && !thermal_shutdown_flag && !bridge_off[0];
      bridge_b_enable <= drv_enable && !thermal_shutdown_flag && !bridge_off[1];
    end
  end

  // ============================================================
  // Step generator: phase accumulator adds |v| per clock, carry at 2^24
  logic [VEL_BITS-1:0] vel_mag;
  logic [`PHASE_BITS:0] phase_sum;
  logic [`PHASE_BITS-1:0] phase;
  logic step_now, run;
  assign vel_mag = internal_velocity_setting[VEL_BITS-1] ?
                   VEL_BITS'(-internal_velocity_setting) : internal_velocity_setting;
  assign run = drv_enable && !thermal_shutdown_flag && bridge_off == 2'b00;
  assign phase_sum = {1'b0, phase} + (`PHASE_BITS+1)'(vel_mag);
  // 2^24 per step equals fclk/2/2^23 rate
  assign step_now = run && phase_sum[`PHASE_BITS];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase <= '0;
    end else if (clk_en && run) begin
      phase <= phase_sum[`PHASE_BITS-1:0];
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      microstep_position_count <= 10'h000;
      microstep_pulse <= 1'b0;
      microstep_dir <= 1'b0;
    end else if (clk_en) begin
      microstep_pulse <= step_now;
      microstep_dir <= internal_velocity_setting[VEL_BITS-1];
      if (step_now) begin
        // Natural 10-bit wrap 1023 to 0
        microstep_position_count <= internal_velocity_setting[VEL_BITS-1] ?
          microstep_position_count - 10'h001 : microstep_position_count + 10'h001;
      end
    end
  end

  // Clocks per microstep; saturates, held at max when stopped
  logic [STEP_INTERVAL_BITS-1:0] interval_cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interval_cnt <= '0;
      step_interval_measure <= '1;
    end else if (clk_en) begin
      if (step_now) begin
        step_interval_measure <= interval_cnt + 1'b1;
        interval_cnt <= '0;
      end else if (interval_cnt != '1) begin
        interval_cnt <= interval_cnt + 1'b1;
      end else begin
        step_interval_measure <= '1;
      end
    end
  end

  // ============================================================
  // Index and fault outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      index_output <= 1'b0;
    end else if (clk_en) begin
      if (global_config[`CFG_INDEX_STEP]) begin
        index_output <= index_output ^ step_now;
      end else begin
        index_output <= microstep_position_count == 10'h000;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_output <= 1'b0;
    end else if (clk_en) begin
      fault_output <= thermal_shutdown_flag || bridge_off != 2'b00 ||
                      (global_config[`CFG_STALL_EN] && stall_s);
    end
  end

  // ============================================================
  // Status, open load is informative only
  assign drv_status = {!bridge_off[1], !bridge_off[0], stall_s, ol_b, ol_a,
                       s_flag_s[1], s_flag_s[0], s_flag_g[1], s_flag_g[0],
                       thermal_shutdown_flag, pw_hot};
  assign irq_event = drv_status[`IRQ_BITS-1:0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= '0;
    end else if (clk_en) begin
      // Set wins over a simultaneous clear
      irq_status <= (irq_status & ~(wr_istat ? wr_val[`IRQ_BITS-1:0] : '0)) | irq_event;
    end
  end
  assign irq = |(irq_status & irq_mask);

  // ============================================================
  // AXI4-Lite read path
  assign arready = !rvalid;
  assign rd_fire = arvalid && arready;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= 2'h0;
    end else if (clk_en) begin
      if (rd_fire) begin
        rvalid <= 1'b1;
        rresp <= 2'h0;
        unique case (araddr)
          `OFS_GLOBAL_CONFIG: rdata <= 32'(global_config);
          `OFS_VELOCITY: rdata <= 32'(internal_velocity_setting);
          `OFS_THERMAL_CFG: rdata <= 32'(thermal_cfg);
          `OFS_DRIVER_CTRL: rdata <= 32'(drv_enable);
          `OFS_DRV_STATUS: rdata <= 32'(drv_status);
          `OFS_POSITION: rdata <= 32'(microstep_position_count);
          `OFS_STEP_INTERVAL: rdata <= 32'(step_interval_measure);
          `OFS_IRQ_STATUS: rdata <= 32'(irq_status);
          `OFS_IRQ_MASK: rdata <= 32'(irq_mask);
          default: begin
            rdata <= 32'h0000_0000;
            rresp <= 2'h2;
          end
        endcase
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ============================================================
  // Assertions
  a_pos_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && step_now && !microstep_dir && !internal_velocity_setting[VEL_BITS-1]
    && microstep_position_count == 10'h3ff |=> microstep_position_count == 10'h000)
    else $error("position did not wrap to zero");
  a_shutdown_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    thermal_shutdown_flag && pw_hot |=> thermal_shutdown_flag)
    else $error("shutdown released above prewarn");
  a_shutdown_bridge: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && thermal_shutdown_flag |=> !bridge_a_enable && !bridge_b_enable)
    else $error("bridge on during shutdown");
  a_short_retry: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(sst[0] == SHORT_LATCHED) |-> $past(srt[0]) == `SHORT_RETRIES)
    else $error("short latched before retries");
  a_short_only: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && bridge_off == 2'b01 && drv_enable && !thermal_shutdown_flag
    |=> !bridge_a_enable && bridge_b_enable)
    else $error("wrong bridge switched off");
  a_short_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    s_flag_g[0] && !(drv_enable && !drv_enable_q) |=> s_flag_g[0])
    else $error("short flag lost without re-enable");
  a_index_tgl: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && global_config[`CFG_INDEX_STEP] && step_now |=> index_output != $past(index_output))
    else $error("index did not toggle on step");
  a_fault_stall: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && global_config[`CFG_STALL_EN] && stall_s |=> fault_output)
    else $error("stall not reported");
  a_vel_direct: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && wr_vel && w_strb_q == 4'hf |=> internal_velocity_setting == VEL_BITS'(w_data_q))
    else $error("velocity not applied directly");
  a_default_therm: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && thermal_cfg == THERMAL_143_PW120 && temp_lvl[1] |=> thermal_shutdown_flag)
    else $error("default thresholds wrong");
  c_step: cover property (@(posedge aclk) disable iff (!aresetn) step_now);
  c_short: cover property (@(posedge aclk) disable iff (!aresetn) bridge_off[0]);
  c_shutdown: cover property (@(posedge aclk) disable iff (!aresetn)
    $fell(thermal_shutdown_flag));
  c_irq: cover property (@(posedge aclk) disable iff (!aresetn) irq);

endmodule

`default_nettype wire

// ==== thermal_sense_model.sv ====
// Far side model: die temperature sensor with four comparator levels.
// Assumes the bench sets the die temperature in whole degrees.
`timescale 1ns/100ps
`default_nettype none

// ============================================================
// Thermometer comparators
module thermal_sense_model (
  input wire logic [7:0] temp_c,
  output logic [3:0] temp_above
);
  // Levels are strictly above each threshold
  assign temp_above = {temp_c > 8'h9d, temp_c > 8'h96, temp_c > 8'h8f, temp_c > 8'h78};
endmodule

`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the step generator and diagnostics block.
// Assumes the register header and the design clocked at 40 MHz.
`timescale 1ns/100ps
`include "step_fault_output_regs.svh"
`default_nettype none

module testbench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [7:0] temp_c = 8'h14;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] d;
  logic [31:0] brs;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [3:0] temp_above;
  logic [3:0] sh = 4'h0;
  logic otp = 1'b0;
  logic clk_en = 1'b1;
  logic [3:0] wstrb = 4'hf;
  logic ol_a = 1'b0;
  logic stall = 1'b0;
  logic idx_q = 1'b0;
  logic br_a, br_b, pulse, dir, fault, index, irq;
  int failures = 0;
  int n_checks = 0;
  int n_pulse = 0;
  int n_tog = 0;

  always #12.5 aclk = ~aclk;
  assign brs = {30'h0, br_a, br_b};

  thermal_sense_model model (.temp_c(temp_c), .temp_above(temp_above));

  step_generator_diagnostics dut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .temp_above(temp_above), .otp_thermal_150(otp), .short_gnd_a(sh[0]),
    .short_gnd_b(sh[1]), .short_sup_a(sh[2]), .short_sup_b(sh[3]),
    .open_load_a(ol_a), .open_load_b(1'b0), .stall_detect(stall),
    .bridge_a_enable(br_a), .bridge_b_enable(br_b), .microstep_pulse(pulse),
    .microstep_dir(dir), .fault_output(fault), .index_output(index), .irq(irq));

  // Counts microsteps and marker toggles for rate checks
  always @(posedge aclk) begin
    if (pulse === 1'b1) n_pulse <= n_pulse + 1;
    if (index !== idx_q) n_tog <= n_tog + 1;
    idx_q <= index;
  end

  // ============================================================
  // Checking and bus tasks
  function automatic logic [31:0] b1(input logic x);
    return {31'h0, x};
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic hang;
    failures++;
    $display("mismatch bus answer expected 1 seen 0");
    stop_test;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (i == 64) hang;
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (i == 64) hang;
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // ============================================================
  // Scenarios
  task automatic t_bus;
    rd(`OFS_GLOBAL_CONFIG);
    chk("config", 32'h0, d);
    rd(`OFS_THERMAL_CFG);
    chk("thermal sel", 32'h0, d);
    rd(8'h24);
    chk("unmapped resp", 32'h2, {30'h0, r});
    chk("unmapped data", 32'h0, d);
    wr(`OFS_DRV_STATUS, 32'h1);
    chk("ro resp", 32'h2, {30'h0, r});
    wr(`OFS_VELOCITY, 32'h12_3456);
    wstrb <= 4'h1;
    wr(`OFS_VELOCITY, 32'hab);
    wstrb <= 4'hf;
    rd(`OFS_VELOCITY);
    chk("byte lane", 32'h12_34ab, d);
    wr(`OFS_VELOCITY, 32'h0);
    $display("done bus");
  endtask

  task automatic t_step;
    int c;
    logic [31:0] p;
    wr(`OFS_DRIVER_CTRL, 32'h1);
    wr(`OFS_VELOCITY, 32'h10_0000);
    wr(`OFS_VELOCITY, 32'h20_0000);
    wr(`OFS_VELOCITY, 32'h30_0000);
    wr(`OFS_VELOCITY, 32'h40_0000);
    c = n_pulse;
    tick(400);
    chk("rate", 32'h1, b1((n_pulse - c) inside {[99:101]}));
    rd(`OFS_STEP_INTERVAL);
    chk("interval", 32'h4, d);
    wr(`OFS_VELOCITY, 32'hc0_0000);
    tick(8);
    chk("dir neg", 32'h1, b1(dir));
    wr(`OFS_VELOCITY, 32'h0);
    tick(8);
    rd(`OFS_POSITION);
    p = d;
    c = n_pulse;
    wr(`OFS_VELOCITY, 32'h7f_ffff);
    tick(2200);
    chk("dir pos", 32'h0, b1(dir));
    wr(`OFS_VELOCITY, 32'h0);
    tick(8);
    rd(`OFS_POSITION);
    chk("position", (p + 32'(n_pulse - c)) & 32'h3ff, d);
    wr(`OFS_GLOBAL_CONFIG, 32'h1);
    tick(4);
    p = 32'(n_tog);
    c = n_pulse;
    wr(`OFS_VELOCITY, 32'h40_0000);
    tick(200);
    wr(`OFS_VELOCITY, 32'h0);
    tick(8);
    chk("toggles", 32'(n_pulse - c), 32'(n_tog) - p);
    // Frozen clock enable must stop the marker toggling
    wr(`OFS_VELOCITY, 32'h40_0000);
    tick(20);
    clk_en <= 1'b0;
    tick(2);
    p = 32'(n_tog);
    tick(40);
    chk("freeze", p, 32'(n_tog));
    clk_en <= 1'b1;
    wr(`OFS_VELOCITY, 32'h0);
    wr(`OFS_GLOBAL_CONFIG, 32'h0);
    rd(`OFS_POSITION);
    chk("zero mark", b1(d == 32'h0), b1(index));
    $display("done step");
  endtask

  task automatic t_thermal;
    int sel[5] = '{0, 1, 2, 3, 0};
    int sd[5] = '{143, 150, 150, 157, 150};
    int pw[5] = '{120, 120, 143, 143, 120};
    for (int k = 0; k < 5; k++) begin
      otp <= (k == 4);
      wr(`OFS_THERMAL_CFG, 32'(sel[k]));
      temp_c <= 8'(pw[k] + 1);
      tick(10);
      rd(`OFS_DRV_STATUS);
      chk("prewarn", 32'h1, d & 32'h3);
      temp_c <= 8'(sd[k] + 1);
      tick(10);
      rd(`OFS_DRV_STATUS);
      chk("shutdown", 32'h3, d & 32'h3);
      chk("off", 32'h0, brs);
      chk("hot fault", 32'h1, b1(fault));
      temp_c <= 8'(pw[k] + 1);
      tick(10);
      chk("held off", 32'h0, brs);
      temp_c <= 8'(pw[k] - 1);
      tick(10);
      rd(`OFS_DRV_STATUS);
      chk("cool", 32'h0, d & 32'h3);
      chk("on", 32'h3, brs);
    end
    otp <= 1'b0;
    temp_c <= 8'h14;
    $display("done thermal");
  endtask

  task automatic t_short;
    wr(`OFS_IRQ_MASK, 32'h4);
    for (int k = 0; k < 4; k++) begin
      sh <= 4'(1 << k);
      tick(2);
      sh <= 4'h0;
      tick(10);
      rd(`OFS_DRV_STATUS);
      chk("glitch", 32'h0, d & 32'h3c);
      sh <= 4'(1 << k);
      tick(12);
      rd(`OFS_DRV_STATUS);
      chk("short", 32'h4 << k, d & 32'h3c);
      chk("one bridge", (k % 2 == 0) ? 32'h1 : 32'h2, brs);
      chk("fault", 32'h1, b1(fault));
      sh <= 4'h0;
      tick(10);
      rd(`OFS_DRV_STATUS);
      chk("held", 32'h4 << k, d & 32'h3c);
      wr(`OFS_DRIVER_CTRL, 32'h0);
      wr(`OFS_DRIVER_CTRL, 32'h1);
      tick(4);
      chk("restart", 32'h3, brs);
    end
    chk("irq set", 32'h1, b1(irq));
    wr(`OFS_IRQ_STATUS, 32'h1ff);
    tick(2);
    chk("irq clr", 32'h0, b1(irq));
    $display("done short");
  endtask

  task automatic t_open;
    wr(`OFS_IRQ_MASK, 32'h0);
    wr(`OFS_VELOCITY, 32'h10_0000);
    ol_a <= 1'b1;
    tick(10);
    chk("masked", 32'h0, b1(irq));
    rd(`OFS_DRV_STATUS);
    chk("open flag", 32'h40, d & 32'h40);
    chk("no action", 32'h3, brs);
    chk("no fault", 32'h0, b1(fault));
    ol_a <= 1'b0;
    wr(`OFS_IRQ_MASK, 32'h40);
    tick(2);
    chk("unmasked", 32'h1, b1(irq));
    wr(`OFS_IRQ_STATUS, 32'h40);
    tick(2);
    chk("w1c", 32'h0, b1(irq));
    stall <= 1'b1;
    tick(10);
    chk("stall off", 32'h0, b1(fault));
    wr(`OFS_GLOBAL_CONFIG, 32'h2);
    tick(4);
    chk("stall on", 32'h1, b1(fault));
    stall <= 1'b0;
    $display("done open");
  endtask

  // ============================================================
  // Main sequence
  initial begin
    tick(20);
    aresetn <= 1'b1;
    t_bus;
    t_step;
    t_thermal;
    t_short;
    t_open;
    stop_test;
  end
endmodule

`default_nettype wire
